//--- twpat_pkg.sv
/*
 Shared constants of the 2-wire potentiometer address and wiper timing
 block. Assumes a 100 MHz system clock; all cycle counts derive from it.
*/
`default_nettype none
package twpat_pkg;
   localparam int unsigned SYS_CLK_MHZ   = 100;
   // Glitch suppression on SCL and SDA
   localparam int unsigned FILTER_NS     = 50;
   localparam int unsigned FILTER_CYC    =
      (FILTER_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int unsigned FILTER_W      = 3;
   // Internal SDA hold across the SCL falling edge
   localparam int unsigned SDA_HOLD_NS   = 300;
   localparam int unsigned SDA_HOLD_CYC  =
      (SDA_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int unsigned HOLD_W        = 5;
   // Wiper response: typical figure is used, maximum is the bound
   localparam int unsigned SETTLE_TYP_US = 2;
   localparam int unsigned SETTLE_MAX_US = 10;
   localparam int unsigned SETTLE_CYC    = SETTLE_TYP_US * SYS_CLK_MHZ;
   localparam int unsigned SETTLE_MAX_CYC = SETTLE_MAX_US * SYS_CLK_MHZ;
   localparam int unsigned SETTLE_W      = 8;
   // Nonvolatile store cycle
   localparam int unsigned STORE_TYP_MS  = 5;
   localparam int unsigned STORE_MAX_MS  = 10;
   localparam int unsigned STORE_CYC     = STORE_TYP_MS * SYS_CLK_MHZ * 1000;
   localparam int unsigned STORE_MAX_CYC = STORE_MAX_MS * SYS_CLK_MHZ * 1000;
   localparam int unsigned STORE_CNT_W   = 20;
   // Potentiometers and address byte
   localparam int unsigned POT_COUNT     = 4;
   localparam int unsigned TAP_W         = 6;
   localparam logic [5:0]  TAP_MAX       = 6'h3f;
   localparam logic [5:0]  TAP_MIN       = 6'h00;
   localparam logic [3:0]  DEV_TYPE      = 4'ha; // Arbitrary type code
   localparam logic [3:0]  ADDR_BITS     = 4'h8;
   localparam logic        LINE_IDLE     = 1'b1;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_ADDR  = 5'h02,
      ST_ACK   = 5'h04,
      ST_ACT   = 5'h08,
      ST_STORE = 5'h10
   } twpat_state_t;
endpackage : twpat_pkg
`default_nettype wire

//--- twpat_in_filter.sv
/*
 Two-flop synchroniser followed by a glitch filter for one bus line.
 Assumes the pin is asynchronous to clk_sys and idles high.
*/
`default_nettype none
module twpat_in_filter
   import twpat_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic clkEn,
   input  wire logic pinIn,
   output logic      levelOut
);
   logic                meta_reg;
   logic                sync_reg;
   logic                level_reg;
   logic                level_next;
   logic [FILTER_W-1:0] cnt_reg;
   logic [FILTER_W-1:0] cnt_next;

   // A new level is taken only after it stood for the whole window
   always_comb begin
      level_next = level_reg;
      cnt_next   = '0;
      if (sync_reg != level_reg) begin
         if (cnt_reg == FILTER_W'(FILTER_CYC - 1)) begin
            level_next = sync_reg; // see [R10]
         end else begin
            cnt_next = cnt_reg + FILTER_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta_reg  <= LINE_IDLE;
         sync_reg  <= LINE_IDLE;
         level_reg <= LINE_IDLE;
         cnt_reg   <= '0;
      end else if (clkEn) begin
         meta_reg  <= pinIn;
         sync_reg  <= meta_reg;
         level_reg <= level_next;
         cnt_reg   <= cnt_next;
      end
   end

   assign levelOut = level_reg;

   property p_glitch_reject;
      @(posedge clk_sys) disable iff (!rstn || !clkEn)
      level_reg != $past(level_reg) |->
         $past(sync_reg, 1) == level_reg && $past(sync_reg, 5) == level_reg;
   endproperty
   a_glitch_reject: assert property (p_glitch_reject) // see [R10]
      else $error("line level taken from a pulse shorter than the filter");
endmodule : twpat_in_filter
`default_nettype wire

//--- twpat_addr_timing.sv
/*
 Slave-address decode, acknowledge and wiper response timing of a quad
 potentiometer on a 2-wire bus. Assumes SCL feeds both sclClk and sclIn,
 SDA is resolved outside from sdaOe, and the command decoder drives
 storeCmd, load and step inputs synchronously to clk_sys.
*/
`default_nettype none
// What this block does
// [R01] The master sends the address byte right after START, before others.
// [R02] The top four address bits must equal the built-in type code.
// [R03] The low four address bits must equal the four straps to acknowledge.
// [R04] A store keeps the device busy for the store time, never over 10 ms.
// [R05] After a load the wiper reaches its new tap within 10 us.
// [R06] In step mode the wiper moves within 10 us of each SCL rising edge.
// [R07] At power-up the wiper settles within 10 us after supply is stable.
// [R08] Power-up recall does not finish before the supply is stable.
// [R09] Incoming SDA is held at least 300 ns past the SCL falling edge.
// [R10] Pulses on SCL and SDA shorter than 50 ns are ignored; bit capture on sclClk takes SCL and SDA unfiltered.
// [R11] A STOP ending a store command starts the store and disables input.
// [R12] While storing, the address is not acknowledged; the master polls.
// [R13] At power-up each wiper loads its first saved position.
module twpat_addr_timing
   import twpat_pkg::*;
#(
   parameter int unsigned StoreCycles = STORE_CYC
) (
   input  wire logic                         clk_sys,
   input  wire logic                         rstn,
   input  wire logic                         clkEn,
   input  wire logic                         sclClk,
   input  wire logic                         sclIn,
   input  wire logic                         sdaIn,
   output logic                              sdaOut,
   output logic                              sdaOe,
   input  wire logic                         addr_strap_bit_zero,
   input  wire logic                         addr_strap_bit_one,
   input  wire logic                         addr_strap_bit_two,
   input  wire logic                         addr_strap_bit_three,
   input  wire logic                         supplyStable,
   input  wire logic [TAP_W*POT_COUNT-1:0]   firstSavedPos,
   input  wire logic                         storeCmd,
   input  wire logic                         loadStb,
   input  wire logic [1:0]                   loadPot,
   input  wire logic [TAP_W-1:0]             loadValue,
   input  wire logic                         stepMode,
   input  wire logic [1:0]                   stepPot,
   output logic                              addrHit,
   output logic                              storeBusy,
   output logic                              recallDone,
   output logic                              wiperSettled,
   output logic [TAP_W*POT_COUNT-1:0]        wiperTap
);
   localparam int SettleBound = SETTLE_MAX_CYC;

   function automatic logic addrMatch(input logic [7:0] addr,
                                      input logic [3:0] strap);
      addrMatch = (addr[7:4] == DEV_TYPE) && (addr[3:0] == strap);
   endfunction : addrMatch

   function automatic logic [TAP_W-1:0] stepTap(input logic [TAP_W-1:0] v,
                                                input logic up);
      stepTap = v;
      if (up && v != TAP_MAX) begin
         stepTap = v + TAP_W'(1);
      end else if (!up && v != TAP_MIN) begin
         stepTap = v - TAP_W'(1);
      end
   endfunction : stepTap

   // Link domain: each SCL rise captures SDA and flips a toggle
   logic linkBit_reg;
   logic linkBit_next;
   logic linkTog_reg;
   logic linkTog_next;

   always_comb begin
      linkBit_next = sdaIn;
      linkTog_next = ~linkTog_reg;
   end

   always_ff @(posedge sclClk or negedge rstn) begin
      if (!rstn) begin
         linkBit_reg <= 1'b0;
         linkTog_reg <= 1'b0;
      end else begin
         linkBit_reg <= linkBit_next;
         linkTog_reg <= linkTog_next;
      end
   end

   // Front end in the system domain
   logic                    sclF;
   logic                    sdaF;
   logic [3:0]              strapMeta_reg;
   logic [3:0]              strapSync_reg;
   logic                    supMeta_reg;
   logic                    supSync_reg;
   logic [SDA_HOLD_CYC-1:0] sdaDly_reg;
   logic [SDA_HOLD_CYC-1:0] sdaDly_next;
   logic [HOLD_W-1:0]       sclHigh_reg;
   logic [HOLD_W-1:0]       sclHigh_next;
   logic                    sclPrev_reg;
   logic                    sdaPrev_reg;
   logic                    togMeta_reg;
   logic                    togSync_reg;
   logic                    togSeen_reg;
   logic                    sdaHold;
   logic                    sclSteady;
   logic                    startDet;
   logic                    stopDet;
   logic                    sclFall;
   logic                    bitStb;

   twpat_in_filter u_scl_filter (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .clkEn    (clkEn),
      .pinIn    (sclIn),
      .levelOut (sclF)
   );

   twpat_in_filter u_sda_filter (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .clkEn    (clkEn),
      .pinIn    (sdaIn),
      .levelOut (sdaF)
   );

   // Delaying SDA and demanding SCL steady high for the same time keeps
   // a data change near either SCL edge from looking like START or STOP
   always_comb begin
      sdaDly_next  = {sdaDly_reg[SDA_HOLD_CYC-2:0], sdaF}; // see [R09]
      sclHigh_next = '0;
      if (sclF) begin
         sclHigh_next = (sclHigh_reg == HOLD_W'(SDA_HOLD_CYC)) ?
                        sclHigh_reg : sclHigh_reg + HOLD_W'(1);
      end
   end

   assign sdaHold   = sdaDly_reg[SDA_HOLD_CYC-1];
   assign sclSteady = sclF &&
                      sclHigh_reg == HOLD_W'(SDA_HOLD_CYC); // see [R09]
   assign startDet  = sclSteady && sdaPrev_reg && !sdaHold;
   assign stopDet   = sclSteady && !sdaPrev_reg && sdaHold;
   assign sclFall   = sclPrev_reg && !sclF;
   assign bitStb    = togSync_reg ^ togSeen_reg;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         strapMeta_reg <= '0;
         strapSync_reg <= '0;
         supMeta_reg   <= 1'b0;
         supSync_reg   <= 1'b0;
         sdaDly_reg    <= '1;
         sclHigh_reg   <= '0;
         sclPrev_reg   <= LINE_IDLE;
         sdaPrev_reg   <= LINE_IDLE;
         togMeta_reg   <= 1'b0;
         togSync_reg   <= 1'b0;
         togSeen_reg   <= 1'b0;
      end else if (clkEn) begin
         strapMeta_reg <= {addr_strap_bit_three, addr_strap_bit_two,
                           addr_strap_bit_one, addr_strap_bit_zero};
         strapSync_reg <= strapMeta_reg;
         supMeta_reg   <= supplyStable;
         supSync_reg   <= supMeta_reg;
         sdaDly_reg    <= sdaDly_next;
         sclHigh_reg   <= sclHigh_next;
         sclPrev_reg   <= sclF;
         sdaPrev_reg   <= sdaHold;
         togMeta_reg   <= linkTog_reg;
         togSync_reg   <= togMeta_reg;
         togSeen_reg   <= togSync_reg;
      end
   end

   // Address decode, acknowledge and store cycle
   twpat_state_t           state_reg;
   twpat_state_t           state_next;
   logic [7:0]             shift_reg;
   logic [7:0]             shift_next;
   logic [3:0]             bitCnt_reg;
   logic [3:0]             bitCnt_next;
   logic [STORE_CNT_W-1:0] storeCnt_reg;
   logic [STORE_CNT_W-1:0] storeCnt_next;
   logic                   sdaOe_reg;
   logic                   addrHit_reg;
   logic                   busy_reg;
   logic                   sdaOut_reg;

   always_comb begin
      state_next    = state_reg;
      shift_next    = shift_reg;
      bitCnt_next   = bitCnt_reg;
      storeCnt_next = storeCnt_reg;
      // Inputs are dead while the store runs, so polls get no acknowledge
      if (state_reg != ST_STORE && startDet) begin // see [R11]
         state_next  = ST_ADDR; // see [R01]
         bitCnt_next = '0;
      end else if (state_reg != ST_STORE && stopDet) begin
         state_next = ST_IDLE;
         if (state_reg == ST_ACT && storeCmd) begin
            state_next    = ST_STORE; // see [R11]
            storeCnt_next = STORE_CNT_W'(StoreCycles - 1); // see [R04]
         end
      end else begin
         case (state_reg)
            ST_ADDR: begin
               if (bitStb && bitCnt_reg != ADDR_BITS) begin
                  shift_next  = {shift_reg[6:0], linkBit_reg};
                  bitCnt_next = bitCnt_reg + 4'h1;
               end
               if (sclFall && bitCnt_reg == ADDR_BITS) begin
                  state_next = addrMatch(shift_reg, strapSync_reg) ?
                               ST_ACK : ST_IDLE; // see [R02] [R03]
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  state_next = ST_ACT;
               end
            end
            ST_STORE: begin
               if (storeCnt_reg == '0) begin
                  state_next = ST_IDLE;
               end else begin
                  storeCnt_next = storeCnt_reg - STORE_CNT_W'(1);
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_reg    <= ST_IDLE;
         shift_reg    <= '0;
         bitCnt_reg   <= '0;
         storeCnt_reg <= '0;
         sdaOe_reg    <= 1'b0;
         addrHit_reg  <= 1'b0;
         busy_reg     <= 1'b0;
         sdaOut_reg   <= 1'b0;
      end else if (clkEn) begin
         state_reg    <= state_next;
         shift_reg    <= shift_next;
         bitCnt_reg   <= bitCnt_next;
         storeCnt_reg <= storeCnt_next;
         sdaOe_reg    <= (state_next == ST_ACK); // see [R03] [R12]
         addrHit_reg  <= (state_next == ST_ACK) || (state_next == ST_ACT);
         busy_reg     <= (state_next == ST_STORE);
         sdaOut_reg   <= 1'b0;
      end
   end

   // Wiper registers, recall and response delay
   logic [TAP_W-1:0]         wiper_reg  [POT_COUNT];
   logic [TAP_W-1:0]         wiper_next [POT_COUNT];
   logic [SETTLE_W-1:0]      settleCnt_reg;
   logic [SETTLE_W-1:0]      settleCnt_next;
   logic                     settled_reg;
   logic                     settled_next;
   logic                     recall_reg;
   logic                     recall_next;
   logic [TAP_W*POT_COUNT-1:0] tap_reg;
   logic [TAP_W*POT_COUNT-1:0] tap_next;
   logic                     changed;

   always_comb begin
      wiper_next  = wiper_reg;
      changed     = 1'b0;
      recall_next = recall_reg | supSync_reg; // see [R08]
      if (!recall_reg) begin
         if (supSync_reg) begin
            for (int i = 0; i < POT_COUNT; i++) begin
               wiper_next[i] = firstSavedPos[i*TAP_W +: TAP_W]; // see [R13]
            end
            changed = 1'b1;
         end
      end else if (loadStb) begin
         wiper_next[loadPot] = loadValue; // see [R05]
         changed = 1'b1;
      end else if (stepMode && state_reg == ST_ACT && bitStb) begin
         wiper_next[stepPot] = stepTap(wiper_reg[stepPot],
                                       linkBit_reg); // see [R06]
         changed = 1'b1;
      end
      // Every change restarts the delay; steps come no faster than SCL
      settled_next   = settled_reg;
      settleCnt_next = settleCnt_reg;
      tap_next       = tap_reg;
      if (changed) begin
         settled_next   = 1'b0;
         settleCnt_next = SETTLE_W'(SETTLE_CYC - 1);
      end else if (!settled_reg && recall_reg) begin
         if (settleCnt_reg == '0) begin
            settled_next = 1'b1; // see [R05] [R06] [R07]
            for (int i = 0; i < POT_COUNT; i++) begin
               tap_next[i*TAP_W +: TAP_W] = wiper_reg[i];
            end
         end else begin
            settleCnt_next = settleCnt_reg - SETTLE_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < POT_COUNT; i++) begin
            wiper_reg[i] <= '0;
         end
         settleCnt_reg <= '0;
         settled_reg   <= 1'b0;
         recall_reg    <= 1'b0;
         tap_reg       <= '0;
      end else if (clkEn) begin
         wiper_reg     <= wiper_next;
         settleCnt_reg <= settleCnt_next;
         settled_reg   <= settled_next;
         recall_reg    <= recall_next;
         tap_reg       <= tap_next;
      end
   end

   assign sdaOut       = sdaOut_reg;
   assign sdaOe        = sdaOe_reg;
   assign addrHit      = addrHit_reg;
   assign storeBusy    = busy_reg;
   assign recallDone   = recall_reg;
   assign wiperSettled = settled_reg;
   assign wiperTap     = tap_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn || !clkEn);

   property p_type_code;
      state_reg == ST_ACK && $past(state_reg) == ST_ADDR |->
         shift_reg[7:4] == DEV_TYPE;
   endproperty
   a_type_code: assert property (p_type_code) // see [R02]
      else $error("acknowledge given with a foreign type code");

   property p_strap_match;
      $rose(sdaOe_reg) |-> shift_reg[3:0] == $past(strapSync_reg)
         && bitCnt_reg == ADDR_BITS;
   endproperty
   a_strap_match: assert property (p_strap_match) // see [R03]
      else $error("acknowledge given with straps not matching");

   property p_busy_noack;
      busy_reg |-> !sdaOe_reg && !addrHit_reg;
   endproperty
   a_busy_noack: assert property (p_busy_noack) // see [R12]
      else $error("address answered during the store cycle");

   property p_store_start;
      state_reg == ST_ACT && stopDet && storeCmd |=> busy_reg ##1 busy_reg;
   endproperty
   a_store_start: assert property (p_store_start) // see [R11]
      else $error("store cycle did not start at STOP");

   property p_store_len;
      busy_reg |-> storeCnt_reg < STORE_CNT_W'(STORE_MAX_CYC);
   endproperty
   a_store_len: assert property (p_store_len) // see [R04]
      else $error("store cycle longer than its maximum");

   property p_load_settle;
      recall_reg && loadStb |=> !settled_reg ##[1:SettleBound] settled_reg;
   endproperty
   a_load_settle: assert property (p_load_settle) // see [R05]
      else $error("wiper did not follow a load in time");

   property p_step_settle;
      recall_reg && !loadStb && stepMode && state_reg == ST_ACT && bitStb
         |=> !settled_reg ##[1:SettleBound] settled_reg;
   endproperty
   a_step_settle: assert property (p_step_settle) // see [R06]
      else $error("wiper did not follow a step in time");

   property p_powerup_settle;
      $rose(recallDone) |-> ##[1:SettleBound] settled_reg;
   endproperty
   a_powerup_settle: assert property (p_powerup_settle) // see [R07]
      else $error("wiper did not settle after power-up");

   property p_recall_wait;
      $rose(recall_reg) |-> $past(supSync_reg);
   endproperty
   a_recall_wait: assert property (p_recall_wait) // see [R08]
      else $error("recall finished before supply was stable");

   property p_recall_value;
      $rose(recall_reg) |-> wiper_reg[0] == $past(firstSavedPos[5:0])
         && wiper_reg[3] == $past(firstSavedPos[23:18]);
   endproperty
   a_recall_value: assert property (p_recall_value) // see [R13]
      else $error("wiper not loaded from first saved position");

   property p_sda_hold;
      startDet || stopDet |-> sclF && $past(sclF, 29);
   endproperty
   a_sda_hold: assert property (p_sda_hold) // see [R09]
      else $error("bus condition seen without SCL held high");
endmodule : twpat_addr_timing
`default_nettype wire

//--- twpat_master.sv
/*
 Behavioural 2-wire bus master: drives SCL and pulls SDA low.
 Assumes SDA is resolved outside with a pull-up; paced by clkLink.
*/
`default_nettype none
module twpat_master (
   input  wire logic clkLink,
   input  wire logic sdaLine,
   output var logic  scl,
   output var logic  sdaPull
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sdaPull = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clkLink);
   endtask : tick
   // SDA moves 320 ns after SCL falls, 20 ns past the device hold window
   task automatic bitOut(input logic b);
      tick(10);
      sdaPull = ~b;
      tick(31);
      scl = 1'b1;
      tick(19);
      scl = 1'b0;
   endtask : bitOut
   // START is always followed by the address byte, then the ack clock
   task automatic xfer(input logic [7:0] b, output logic ack);
      tick(19);
      sdaPull = 1'b1;
      tick(19);
      scl = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         bitOut(b[i]);
      end
      tick(10);
      sdaPull = 1'b0;
      tick(31);
      scl = 1'b1;
      tick(9);
      ack = ~sdaLine;
      tick(10);
      scl = 1'b0;
   endtask : xfer
   task automatic stop;
      tick(10);
      sdaPull = 1'b1;
      tick(31);
      scl = 1'b1;
      tick(19);
      sdaPull = 1'b0;
      tick(41);
   endtask : stop
endmodule : twpat_master
`default_nettype wire

//--- twpat_addr_timing_bench.sv
/*
 Self-checking bench of the address decode and wiper timing block.
 Assumes twpat_pkg and the bus master model twpat_master.
*/
`default_nettype none
module twpat_addr_timing_bench
   import twpat_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STORE_SIM = 3000;
   localparam logic [23:0] SAVED = {6'h3e, 6'h01, 6'h15, 6'h2a};
   localparam logic [7:0]  HIT = {DEV_TYPE, 4'h5};
   // Address, straps, expected acknowledge
   localparam logic [12:0] ROWS [6] = '{
      {HIT, 4'h5, 1'b1}, {DEV_TYPE, 4'ha, 4'ha, 1'b1},
      {DEV_TYPE, 4'h4, 4'h5, 1'b0}, {DEV_TYPE, 4'hd, 4'h5, 1'b0},
      {~DEV_TYPE, 4'h5, 4'h5, 1'b0},
      {DEV_TYPE ^ 4'h1, 4'h5, 4'h5, 1'b0}};
   logic        clk_sys, clkLink, rstn, scl, sdaPull, sdaLine, ack;
   logic        sdaOut, sdaOe, supplyStable, storeCmd, loadStb, stepMode;
   logic        addrHit, storeBusy, recallDone, wiperSettled;
   logic [3:0]  strap;
   logic [1:0]  loadPot, stepPot;
   logic [5:0]  loadValue;
   logic [23:0] wiperTap;
   int          busyCnt = 0;
   int          nFail = 0;
   int          checks = 0;
   // Open drain with pull-up: released means high
   assign sdaLine = ~(sdaPull | (sdaOe & ~sdaOut));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      clkLink = 1'b0;
      #3;
      forever #16 clkLink = ~clkLink;
   end
   always @(posedge clk_sys) if (storeBusy === 1'b1) busyCnt++;
   twpat_master i_twpat_master (.clkLink(clkLink), .sdaLine(sdaLine),
      .scl(scl), .sdaPull(sdaPull));
   twpat_addr_timing #(.StoreCycles(STORE_SIM)) i_twpat_addr_timing (
      .clk_sys(clk_sys), .rstn(rstn), .clkEn(1'b1), .sclClk(scl),
      .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .addr_strap_bit_zero(strap[0]), .addr_strap_bit_one(strap[1]),
      .addr_strap_bit_two(strap[2]), .addr_strap_bit_three(strap[3]),
      .supplyStable(supplyStable), .firstSavedPos(SAVED),
      .storeCmd(storeCmd), .loadStb(loadStb), .loadPot(loadPot),
      .loadValue(loadValue), .stepMode(stepMode), .stepPot(stepPot),
      .addrHit(addrHit), .storeBusy(storeBusy), .recallDone(recallDone),
      .wiperSettled(wiperSettled), .wiperTap(wiperTap));
   task automatic end_of_test;
      $display("Comparisons %0d mismatches %0d", checks, nFail);
      if (nFail == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic chkBit(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         nFail++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask : chkBit
   task automatic chkVec(input string n, input logic [23:0] e,
                         input logic [23:0] g);
      checks++;
      if (g !== e) begin
         nFail++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chkVec
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   // Bounded wait on wiperSettled (sel 0) or storeBusy (sel 1)
   task automatic waitUntil(input int sel, input logic lvl, input int lim);
      int k = 0;
      while (((sel == 0) ? wiperSettled : storeBusy) !== lvl && k < lim)
      begin
         @(negedge clk_sys);
         k++;
      end
      if (k >= lim) begin
         nFail++;
         $display("CHECK FAILED wait %0d expected %b seen timeout", sel, lvl);
         end_of_test();
      end
   endtask : waitUntil
   task automatic xferChk(input logic [7:0] a, input logic e);
      i_twpat_master.xfer(a, ack);
      chkBit("ack", e, ack);
      chkBit("addrHit", e, addrHit);
   endtask : xferChk
   task automatic chkReset;
      chkBit("sdaOe", 1'b0, sdaOe);
      chkBit("addrHit", 1'b0, addrHit);
      chkBit("storeBusy", 1'b0, storeBusy);
      chkBit("recallDone", 1'b0, recallDone);
      chkBit("wiperSettled", 1'b0, wiperSettled);
      chkVec("wiperTap", 24'h0, wiperTap);
   endtask : chkReset
   task automatic load(input logic [1:0] p, input logic [5:0] v);
      loadPot = p;
      loadValue = v;
      loadStb = 1'b1;
      cyc(1);
      loadStb = 1'b0;
   endtask : load
   initial begin
      {rstn, supplyStable, storeCmd, loadStb, stepMode} = 5'h00;
      {strap, loadPot, stepPot, loadValue} = 14'h1400;
      cyc(20);
      chkReset();
      rstn = 1'b1;
      cyc(50);
      chkBit("recallDone", 1'b0, recallDone);
      load(2'd0, 6'h07);
      supplyStable = 1'b1;
      waitUntil(0, 1'b1, 1000);
      chkBit("recallDone", 1'b1, recallDone);
      chkVec("recalled", SAVED, wiperTap);
      for (int i = 0; i < 6; i++) begin
         strap = ROWS[i][4:1];
         cyc(10);
         xferChk(ROWS[i][12:5], ROWS[i][0]);
         i_twpat_master.stop();
         cyc(60);
         chkBit("addrHit idle", 1'b0, addrHit);
      end
      load(2'd1, 6'h30);
      cyc(2);
      chkBit("settled", 1'b0, wiperSettled);
      waitUntil(0, 1'b1, 1000);
      chkVec("loaded", {6'h3e, 6'h01, 6'h30, 6'h2a}, wiperTap);
      // Steps run into the rails to check saturation
      for (int d = 0; d < 2; d++) begin
         stepMode = 1'b1;
         stepPot = (d == 0) ? 2'd3 : 2'd2;
         xferChk(HIT, 1'b1);
         repeat (3) i_twpat_master.bitOut(d == 0);
         // The SCL pulse of STOP would count as one more step
         cyc(1);
         stepMode = 1'b0;
         i_twpat_master.stop();
         waitUntil(0, 1'b1, 1000);
      end
      chkVec("stepped", {6'h3f, 6'h00, 6'h30, 6'h2a}, wiperTap);
      storeCmd = 1'b1;
      xferChk(HIT, 1'b1);
      i_twpat_master.stop();
      cyc(1);
      storeCmd = 1'b0;
      cyc(60);
      chkBit("storeBusy", 1'b1, storeBusy);
      xferChk(HIT, 1'b0);
      i_twpat_master.stop();
      waitUntil(1, 1'b0, 4000);
      chkVec("busy cycles", 24'(STORE_SIM), 24'(busyCnt));
      cyc(5);
      xferChk(HIT, 1'b1);
      i_twpat_master.stop();
      cyc(5);
      rstn = 1'b0;
      cyc(2);
      chkReset();
      rstn = 1'b1;
      // Supply is already stable, so recall follows the synchroniser
      cyc(1);
      chkBit("recallDone", 1'b0, recallDone);
      waitUntil(0, 1'b1, 1000);
      chkVec("recalled", SAVED, wiperTap);
      end_of_test();
   end
endmodule : twpat_addr_timing_bench
`default_nettype wire
